// ===== rtl/ft_mode_pkg.sv
// Constants for the timer feature and mode control register bank.
// Assumes one 40 MHz clock and a plain register port with 8-bit byte addresses.
//
// Function
// - Bits 31 to 8 of the mode register read as zero and ignore writes.
// - With the fault interrupt enable set and fault control on, a detected fault raises the fault interrupt.
// - The two-bit fault mode selects off, even channels manual, all channels manual, or all channels automatic.
// - While write protection is on, fault mode, capture test enable and extended enable keep their value.
// - The capture test enable bit puts the module into capture test mode while it is one.
// - With the restriction bit set, software triggers load modulo and channel values, hardware load mask and counter.
// - The restriction bit steers triggers only while the synchronisation scheme select is zero.
// - The protection disable bit is always the inverse of the protection enable bit, and writing one to enable clears it.
// - Disable is set only by reading the enable bit as one and then writing one to disable; writing zero does nothing.
// - Writing one to the preset strobe forces every channel output to its preset level; writing zero does nothing.
// - The preset strobe bit always reads as zero.
// - The extended register enable reports whether the extended register set may be used.
package ft_mode_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NCH = 8;
    localparam int MODE_W = 8;
    localparam int IRQ_W = 2;

    // Byte addresses of the register words
    localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STAT = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_PRESET = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_SCFG = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ST = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_SWTRIG = 8'h18;

    // Mode register fields
    localparam int B_FIE = 7;
    localparam int B_FCM_HI = 6;
    localparam int B_FCM_LO = 5;
    localparam int B_CTE = 4;
    localparam int B_STR = 3;
    localparam int B_WPD = 2;
    localparam int B_INIT = 1;
    localparam int B_XEN = 0;

    // Status register fields
    localparam int B_FFLAG = 0;
    localparam int B_LOCK = 1;

    // Other single-bit fields
    localparam int B_SCHEME = 0;
    localparam int B_SWTRIG = 0;
    localparam int IRQ_FAULT = 0;
    localparam int IRQ_PRESET = 1;

    // Channel groups for fault control
    localparam logic [NCH-1:0] EVEN_CH = 8'h55;
    localparam logic [NCH-1:0] ALL_CH = 8'hFF;
    localparam logic [NCH-1:0] NO_CH = 8'h00;

    // Reset values
    localparam logic RST_WPD = 1'b1;
    localparam logic [NCH-1:0] RST_PRESET = 8'h00;
    localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 2'h0;
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h00000000;

    typedef enum logic [1:0] {
        FM_OFF = 2'b00,
        FM_EVEN_MAN = 2'b01,
        FM_ALL_MAN = 2'b10,
        FM_ALL_AUTO = 2'b11
    } fault_mode_t;
endpackage : ft_mode_pkg

// ===== rtl/sticky_bit.sv
// Sticky flag cell: hardware set, any clear, set wins.
// Assumes set and clear are synchronous to the clock.
module sticky_bit (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Control
    input wire logic set_in,
    input wire logic clr_in,
    // State
    output logic q
);
    // Set beats clear so an event in the clearing cycle survives
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            q <= 1'b0;
        end
        else if (set_in)
        begin
            q <= 1'b1;
        end
        else if (clr_in)
        begin
            q <= 1'b0;
        end
    end
endmodule : sticky_bit

// ===== rtl/ft_mode_ctrl.sv
// Feature and mode control register bank of a multi-channel timer.
// Assumes a single-cycle register port and synchronous fault and trigger inputs.
//
// Our own choices: the register offsets and the strobed register port.
module ft_mode_ctrl (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Register port
    input wire logic [ft_mode_pkg::ADDR_W-1:0] addr,
    input wire logic [ft_mode_pkg::DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [ft_mode_pkg::DATA_W-1:0] rdata,
    // Fault and trigger inputs
    input wire logic [ft_mode_pkg::NCH-1:0] fault_in,
    input wire logic hw_trig,
    // Fault control
    output logic [ft_mode_pkg::NCH-1:0] fault_chan_en,
    output logic fault_auto_clear,
    output logic fault_irq,
    // Modes
    output logic capture_test_mode,
    output logic extended_regs_enable,
    // Synchronisation loads
    output logic upd_modulo_val,
    output logic upd_mask_cnt,
    // Channel output preset
    output logic chan_preset_load,
    output logic [ft_mode_pkg::NCH-1:0] chan_preset_level,
    // Interrupt
    output logic irq
);
    logic fault_irq_enable_r;
    logic [1:0] fault_ctrl_mode_r;
    logic capture_test_enable_r;
    logic sync_trigger_restrict_r;
    logic wprot_disable_r;
    logic extended_regs_enable_r;
    logic unlock_armed_r;
    logic sync_scheme_select_r;
    logic [ft_mode_pkg::NCH-1:0] output_preset_values_r;
    logic [ft_mode_pkg::IRQ_W-1:0] irq_mask_r;
    logic [ft_mode_pkg::IRQ_W-1:0] irq_st;
    logic [ft_mode_pkg::IRQ_W-1:0] irq_set;
    logic [ft_mode_pkg::DATA_W-1:0] rd_mux;
    logic [ft_mode_pkg::DATA_W-1:0] rdata_r;
    logic [ft_mode_pkg::NCH-1:0] chan_en;
    logic [ft_mode_pkg::NCH-1:0] preset_level_r;
    logic preset_load_r;
    logic upd_modulo_val_r;
    logic upd_mask_cnt_r;
    logic fault_flag;
    logic fault_det;
    logic fault_clr;
    logic fault_on;
    logic wr_mode;
    logic wr_stat;
    logic rd_stat;
    logic rd_irq;
    logic sw_trig;
    logic modulo_val_nxt;
    logic mask_cnt_nxt;

    assign wr_mode = wr_en && (addr == ft_mode_pkg::OFS_MODE);
    assign wr_stat = wr_en && (addr == ft_mode_pkg::OFS_STAT);
    assign rd_stat = rd_en && (addr == ft_mode_pkg::OFS_STAT);
    assign rd_irq = rd_en && (addr == ft_mode_pkg::OFS_IRQ_ST);
    assign sw_trig = wr_en && (addr == ft_mode_pkg::OFS_SWTRIG) && wdata[ft_mode_pkg::B_SWTRIG];

    // Unprotected mode fields
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fault_irq_enable_r <= 1'b0;
            sync_trigger_restrict_r <= 1'b0;
        end
        else if (wr_mode)
        begin
            fault_irq_enable_r <= wdata[ft_mode_pkg::B_FIE];
            sync_trigger_restrict_r <= wdata[ft_mode_pkg::B_STR];
        end
    end

    // Protected fields; the check uses the state before this write
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fault_ctrl_mode_r <= ft_mode_pkg::FM_OFF;
            capture_test_enable_r <= 1'b0;
            extended_regs_enable_r <= 1'b0;
        end
        else if (wr_mode && wprot_disable_r)
        begin
            fault_ctrl_mode_r <= wdata[ft_mode_pkg::B_FCM_HI:ft_mode_pkg::B_FCM_LO];
            capture_test_enable_r <= wdata[ft_mode_pkg::B_CTE];
            extended_regs_enable_r <= wdata[ft_mode_pkg::B_XEN];
        end
    end

    // Read of the enable bit as one arms the unlock
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            unlock_armed_r <= 1'b0;
        end
        else if (rd_stat && !wprot_disable_r)
        begin
            unlock_armed_r <= 1'b1;
        end
        else if (wr_mode || wr_stat)
        begin
            unlock_armed_r <= 1'b0;
        end
    end

    // Protection: locking wins over unlocking
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wprot_disable_r <= ft_mode_pkg::RST_WPD;
        end
        else if (wr_stat && wdata[ft_mode_pkg::B_LOCK])
        begin
            wprot_disable_r <= 1'b0;
        end
        else if (wr_mode && wdata[ft_mode_pkg::B_WPD] && unlock_armed_r)
        begin
            wprot_disable_r <= 1'b1;
        end
    end

    // Preset values, scheme select and interrupt mask
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            output_preset_values_r <= ft_mode_pkg::RST_PRESET;
            sync_scheme_select_r <= 1'b0;
            irq_mask_r <= ft_mode_pkg::RST_IRQ_MASK;
        end
        else if (wr_en)
        begin
            case (addr)
                ft_mode_pkg::OFS_PRESET: output_preset_values_r <= wdata[ft_mode_pkg::NCH-1:0];
                ft_mode_pkg::OFS_SCFG: sync_scheme_select_r <= wdata[ft_mode_pkg::B_SCHEME];
                ft_mode_pkg::OFS_IRQ_MASK: irq_mask_r <= wdata[ft_mode_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Channel preset strobe; nothing is stored, so the bit reads zero
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            preset_load_r <= 1'b0;
            preset_level_r <= ft_mode_pkg::RST_PRESET;
        end
        else
        begin
            preset_load_r <= wr_mode && wdata[ft_mode_pkg::B_INIT];
            if (wr_mode && wdata[ft_mode_pkg::B_INIT])
            begin
                preset_level_r <= output_preset_values_r;
            end
        end
    end

    // Fault channel decode
    always_comb
    begin
        case (ft_mode_pkg::fault_mode_t'(fault_ctrl_mode_r))
            ft_mode_pkg::FM_OFF: chan_en = ft_mode_pkg::NO_CH;
            ft_mode_pkg::FM_EVEN_MAN: chan_en = ft_mode_pkg::EVEN_CH;
            ft_mode_pkg::FM_ALL_MAN: chan_en = ft_mode_pkg::ALL_CH;
            ft_mode_pkg::FM_ALL_AUTO: chan_en = ft_mode_pkg::ALL_CH;
            default: chan_en = ft_mode_pkg::NO_CH;
        endcase
    end

    assign fault_on = (fault_ctrl_mode_r != ft_mode_pkg::FM_OFF);
    assign fault_det = |(fault_in & chan_en);
    // Manual modes clear on a zero write; automatic clears once inputs are quiet
    assign fault_clr = (fault_ctrl_mode_r == ft_mode_pkg::FM_ALL_AUTO) ? !fault_det
        : (wr_stat && !wdata[ft_mode_pkg::B_FFLAG]);

    sticky_bit u_fault_flag (
        .clock(clock),
        .arst_n(arst_n),
        .set_in(fault_det),
        .clr_in(fault_clr),
        .q(fault_flag)
    );

    // Trigger routing
    always_comb
    begin
        if (sync_scheme_select_r || !sync_trigger_restrict_r)
        begin
            modulo_val_nxt = sw_trig || hw_trig;
            mask_cnt_nxt = sw_trig || hw_trig;
        end
        else
        begin
            modulo_val_nxt = sw_trig;
            mask_cnt_nxt = hw_trig;
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            upd_modulo_val_r <= 1'b0;
            upd_mask_cnt_r <= 1'b0;
        end
        else
        begin
            upd_modulo_val_r <= modulo_val_nxt;
            upd_mask_cnt_r <= mask_cnt_nxt;
        end
    end

    // Interrupt status, cleared by reading it
    assign irq_set[ft_mode_pkg::IRQ_FAULT] = fault_det && !fault_flag;
    assign irq_set[ft_mode_pkg::IRQ_PRESET] = wr_mode && wdata[ft_mode_pkg::B_INIT];

    genvar gi;
    generate
        for (gi = 0; gi < ft_mode_pkg::IRQ_W; gi++)
        begin : g_irq
            sticky_bit u_st (
                .clock(clock),
                .arst_n(arst_n),
                .set_in(irq_set[gi]),
                .clr_in(rd_irq),
                .q(irq_st[gi])
            );
        end
    endgenerate

    // Read mux; upper bits stay zero
    always_comb
    begin
        rd_mux = ft_mode_pkg::ZERO_WORD;
        case (addr)
            ft_mode_pkg::OFS_MODE:
            begin
                rd_mux[ft_mode_pkg::B_FIE] = fault_irq_enable_r;
                rd_mux[ft_mode_pkg::B_FCM_HI:ft_mode_pkg::B_FCM_LO] = fault_ctrl_mode_r;
                rd_mux[ft_mode_pkg::B_CTE] = capture_test_enable_r;
                rd_mux[ft_mode_pkg::B_STR] = sync_trigger_restrict_r;
                rd_mux[ft_mode_pkg::B_WPD] = wprot_disable_r;
                rd_mux[ft_mode_pkg::B_XEN] = extended_regs_enable_r;
            end
            ft_mode_pkg::OFS_STAT:
            begin
                rd_mux[ft_mode_pkg::B_FFLAG] = fault_flag;
                rd_mux[ft_mode_pkg::B_LOCK] = !wprot_disable_r;
            end
            ft_mode_pkg::OFS_PRESET: rd_mux[ft_mode_pkg::NCH-1:0] = output_preset_values_r;
            ft_mode_pkg::OFS_SCFG: rd_mux[ft_mode_pkg::B_SCHEME] = sync_scheme_select_r;
            ft_mode_pkg::OFS_IRQ_ST: rd_mux[ft_mode_pkg::IRQ_W-1:0] = irq_st;
            ft_mode_pkg::OFS_IRQ_MASK: rd_mux[ft_mode_pkg::IRQ_W-1:0] = irq_mask_r;
            default: rd_mux = ft_mode_pkg::ZERO_WORD;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata_r <= ft_mode_pkg::ZERO_WORD;
        end
        else if (rd_en)
        begin
            rdata_r <= rd_mux;
        end
    end

    assign rdata = rdata_r;
    assign fault_chan_en = chan_en;
    assign fault_auto_clear = (fault_ctrl_mode_r == ft_mode_pkg::FM_ALL_AUTO);
    assign fault_irq = fault_flag && fault_irq_enable_r && fault_on;
    assign capture_test_mode = capture_test_enable_r;
    assign extended_regs_enable = extended_regs_enable_r;
    assign upd_modulo_val = upd_modulo_val_r;
    assign upd_mask_cnt = upd_mask_cnt_r;
    assign chan_preset_load = preset_load_r;
    assign chan_preset_level = preset_level_r;
    assign irq = |(irq_st & irq_mask_r);

    a_rsvd_read_zero: assert property (
        @(posedge clock) disable iff (!arst_n)
        rd_en && addr == ft_mode_pkg::OFS_MODE |=> rdata[ft_mode_pkg::DATA_W-1:ft_mode_pkg::MODE_W] == 24'h000000)
        else $error("mode upper bits not zero");

    a_fault_irq_on: assert property (
        @(posedge clock) disable iff (!arst_n)
        fault_det && fault_irq_enable_r && !wr_mode |=> fault_irq)
        else $error("fault irq missing");

    a_fault_chan_map: assert property (
        @(posedge clock) disable iff (!arst_n)
        fault_ctrl_mode_r == ft_mode_pkg::FM_EVEN_MAN |-> fault_chan_en == ft_mode_pkg::EVEN_CH)
        else $error("even channel map wrong");

    a_prot_hold: assert property (
        @(posedge clock) disable iff (!arst_n)
        wr_mode && !wprot_disable_r |=> $stable(fault_ctrl_mode_r) && $stable(capture_test_enable_r)
            && $stable(extended_regs_enable_r))
        else $error("protected field changed");

    a_capt_follow: assert property (
        @(posedge clock) disable iff (!arst_n)
        wr_mode && wprot_disable_r |=> capture_test_mode == $past(wdata[ft_mode_pkg::B_CTE]))
        else $error("capture test not taken");

    a_route_restrict: assert property (
        @(posedge clock) disable iff (!arst_n)
        hw_trig && !sw_trig && sync_trigger_restrict_r && !sync_scheme_select_r
            |=> upd_mask_cnt && !upd_modulo_val)
        else $error("restricted routing wrong");

    a_route_scheme: assert property (
        @(posedge clock) disable iff (!arst_n)
        hw_trig && sync_scheme_select_r |=> upd_modulo_val && upd_mask_cnt)
        else $error("scheme routing wrong");

    a_lock_write: assert property (
        @(posedge clock) disable iff (!arst_n)
        wr_stat && wdata[ft_mode_pkg::B_LOCK] |=> !wprot_disable_r ##1 !wprot_disable_r)
        else $error("lock not applied");

    a_unlock_seq: assert property (
        @(posedge clock) disable iff (!arst_n)
        !wprot_disable_r && !unlock_armed_r |=> !wprot_disable_r)
        else $error("unlocked without read");

    a_preset_load: assert property (
        @(posedge clock) disable iff (!arst_n)
        wr_mode && wdata[ft_mode_pkg::B_INIT] |=> chan_preset_load
            && chan_preset_level == $past(output_preset_values_r))
        else $error("preset not applied");

    a_init_reads_zero: assert property (
        @(posedge clock) disable iff (!arst_n)
        rd_en && addr == ft_mode_pkg::OFS_MODE |=> !rdata[ft_mode_pkg::B_INIT])
        else $error("init bit read as one");

    a_ext_follow: assert property (
        @(posedge clock) disable iff (!arst_n)
        wr_mode && wprot_disable_r |=> extended_regs_enable == $past(wdata[ft_mode_pkg::B_XEN]))
        else $error("extended enable not taken");

    a_irq_hold: assert property (
        @(posedge clock) disable iff (!arst_n)
        fault_irq && !wr_mode && !wr_stat && !fault_auto_clear |=> fault_irq)
        else $error("fault irq dropped");
endmodule : ft_mode_ctrl

// ===== tb/ft_mode_ctrl_tb.sv
// Self-checking bench for the timer feature and mode control register bank.
// Assumes the design package is compiled first; the bench drives every port itself.
module ft_mode_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock;
    logic arst_n;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr_en;
    logic rd_en;
    logic [31:0] rdata;
    logic [7:0] fault_in;
    logic hw_trig;
    logic [7:0] fault_chan_en;
    logic fault_auto_clear;
    logic fault_irq;
    logic capture_test_mode;
    logic extended_regs_enable;
    logic upd_modulo_val;
    logic upd_mask_cnt;
    logic chan_preset_load;
    logic [7:0] chan_preset_level;
    logic irq;
    int mismatches = 0;
    int samples_checked = 0;
    int n_modulo = 0;
    int n_mask = 0;
    int n_pre = 0;
    logic [31:0] v;

    ft_mode_ctrl i_dut (.clock(clock), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .fault_in(fault_in), .hw_trig(hw_trig),
        .fault_chan_en(fault_chan_en), .fault_auto_clear(fault_auto_clear), .fault_irq(fault_irq),
        .capture_test_mode(capture_test_mode), .extended_regs_enable(extended_regs_enable),
        .upd_modulo_val(upd_modulo_val), .upd_mask_cnt(upd_mask_cnt), .chan_preset_load(chan_preset_load),
        .chan_preset_level(chan_preset_level), .irq(irq));

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // Pulse counters, sampled mid-cycle so no edge race can miss or double a pulse
    always @(negedge clock)
    begin
        n_modulo += int'(upd_modulo_val === 1'b1);
        n_mask += int'(upd_mask_cnt === 1'b1);
        n_pre += int'(chan_preset_load === 1'b1);
    end

    task automatic test_done();
        if (mismatches == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask : rd

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        check(name, d, exp);
    endtask : rd_chk

    task automatic reset_values();
        rd_chk("mode_rst", 8'h00, 32'h00000004);
        rd_chk("status_rst", 8'h04, 32'h00000000);
        rd_chk("unmapped", 8'h1C, 32'h00000000);
        check("cte_rst", 32'(capture_test_mode), 32'h0);
    endtask : reset_values

    task automatic fault_modes();
        logic [31:0] w;
        logic [7:0] ch [4] = '{8'h00, 8'h55, 8'hFF, 8'hFF};
        for (int m = 0; m < 4; m++)
        begin
            w = 32'((m << 5) | 4 | ((m & 1) << 4) | (m >> 1));
            wr(8'h00, w);
            tick(2);
            check("chan_en", 32'(fault_chan_en), 32'(ch[m]));
            check("auto_clr", 32'(fault_auto_clear), 32'(m == 3));
            check("cte", 32'(capture_test_mode), 32'(m & 1));
            check("xen", 32'(extended_regs_enable), 32'(m >> 1));
            rd_chk("mode_rb", 8'h00, w);
        end
    endtask : fault_modes

    task automatic reserved_preset();
        wr(8'h1C, 32'hFFFFFFFF);
        rd_chk("unmapped_wr", 8'h1C, 32'h00000000);
        wr(8'h08, 32'hFFFFFFA5);
        n_pre = 0;
        wr(8'h00, 32'hFFFFFFFF);
        tick(3);
        check("preset_cnt", 32'(n_pre), 32'h1);
        check("preset_lvl", 32'(chan_preset_level), 32'h000000A5);
        rd_chk("mode_fd", 8'h00, 32'h000000FD);
        wr(8'h00, 32'h00000004);
        tick(3);
        check("preset_zero", 32'(n_pre), 32'h1);
    endtask : reserved_preset

    task automatic irq_flow();
        check("irq_masked", 32'(irq), 32'h0);
        wr(8'h14, 32'h00000002);
        tick(2);
        check("irq_on", 32'(irq), 32'h1);
        rd_chk("irq_st", 8'h10, 32'h00000002);
        tick(2);
        check("irq_clr", 32'(irq), 32'h0);
        rd_chk("irq_st2", 8'h10, 32'h00000000);
    endtask : irq_flow

    task automatic fault_flow();
        wr(8'h00, 32'h000000A4);
        fault_in <= 8'h02;
        tick(3);
        check("odd_fault", 32'(fault_irq), 32'h0);
        @(posedge clock);
        fault_in <= 8'h01;
        tick(3);
        check("even_fault", 32'(fault_irq), 32'h1);
        @(posedge clock);
        fault_in <= 8'h00;
        tick(3);
        check("fault_hold", 32'(fault_irq), 32'h1);
        wr(8'h00, 32'h00000024);
        tick(2);
        check("fie_off", 32'(fault_irq), 32'h0);
        wr(8'h00, 32'h000000A4);
        tick(2);
        check("fie_back", 32'(fault_irq), 32'h1);
        wr(8'h04, 32'h00000000);
        tick(2);
        check("flag_clr", 32'(fault_irq), 32'h0);
        rd_chk("irq_fault", 8'h10, 32'h00000001);
        wr(8'h00, 32'h000000E4);
        fault_in <= 8'hFF;
        tick(3);
        check("auto_set", 32'(fault_irq), 32'h1);
        @(posedge clock);
        fault_in <= 8'h00;
        tick(4);
        check("auto_clr", 32'(fault_irq), 32'h0);
    endtask : fault_flow

    task automatic sync_routing();
        logic lim;
        for (int s = 0; s < 2; s++)
            for (int r = 0; r < 2; r++)
            begin
                lim = (r == 1) && (s == 0);
                wr(8'h0C, 32'(s));
                wr(8'h00, 32'((r << 3) | 4));
                n_modulo = 0;
                n_mask = 0;
                wr(8'h18, 32'h00000001);
                tick(3);
                check("sw_modulo", 32'(n_modulo), 32'(1));
                check("sw_mask", 32'(n_mask), 32'(!lim));
                n_modulo = 0;
                n_mask = 0;
                @(posedge clock);
                hw_trig <= 1'b1;
                @(posedge clock);
                hw_trig <= 1'b0;
                tick(3);
                check("hw_modulo", 32'(n_modulo), 32'(!lim));
                check("hw_mask", 32'(n_mask), 32'(1));
            end
    endtask : sync_routing

    task automatic protection();
        wr(8'h00, 32'h00000004);
        wr(8'h04, 32'h00000002);
        rd_chk("locked", 8'h00, 32'h00000000);
        rd_chk("lock_flag", 8'h04, 32'h00000002);
        wr(8'h00, 32'h000000F1);
        rd_chk("prot_keep", 8'h00, 32'h00000080);
        check("cte_lock", 32'(capture_test_mode), 32'h0);
        check("xen_lock", 32'(extended_regs_enable), 32'h0);
        // Write without a fresh read of the enable bit must not unlock
        wr(8'h00, 32'h00000004);
        rd_chk("no_unlock", 8'h00, 32'h00000000);
        rd_chk("arm", 8'h04, 32'h00000002);
        wr(8'h00, 32'h00000075);
        rd_chk("unlock", 8'h00, 32'h00000004);
        rd_chk("lock_off", 8'h04, 32'h00000000);
        wr(8'h00, 32'h00000071);
        rd_chk("wpd_zero", 8'h00, 32'h00000075);
        check("cte_on", 32'(capture_test_mode), 32'h1);
        check("xen_on", 32'(extended_regs_enable), 32'h1);
    endtask : protection

    // Watchdog: the run is short, so any stall ends here
    initial
    begin
        repeat (5000) @(posedge clock);
        mismatches++;
        test_done();
    end

    initial
    begin
        arst_n = 1'b0;
        addr = 8'h00;
        wdata = 32'h00000000;
        wr_en = 1'b0;
        rd_en = 1'b0;
        fault_in = 8'h00;
        hw_trig = 1'b0;
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        reset_values();
        fault_modes();
        reserved_preset();
        irq_flow();
        fault_flow();
        sync_routing();
        protection();
        tick(2);
        test_done();
    end
endmodule : ft_mode_ctrl_tb
